//--- core/vspf_pkg.sv
// video side port formatter: shared constants and types
// assumes a single core clock; no software-visible registers
package vspf_pkg;

	// port signalling standards, one selected at a time
	typedef enum logic [2:0] {
		VSPF_MODE_DSYNC8,
		VSPF_MODE_EMB656,
		VSPF_MODE_VIP,
		VSPF_MODE_ZOOM,
		VSPF_MODE_DIRECT16,
		VSPF_MODE_RAWDTV
	} vspf_mode_t;

	// nominal pixel clock of the port, kept for reference
	localparam int VSPF_LLC_KHZ = 27000;
	// core cycles per port clock period
	localparam int VSPF_DIV_FULL = 2;
	localparam int VSPF_DIV_HALF = 4;

	// timing reference bytes
	localparam logic [7:0] VSPF_PREAMBLE_HI = 8'hFF;
	localparam logic [7:0] VSPF_PREAMBLE_LO = 8'h00;
	// empty cycle marker for discontinuous streams
	localparam logic [7:0] VSPF_EMPTY_BYTE = 8'h00;
	// blanking level pair, chroma then luma
	localparam logic [7:0] VSPF_BLANK_C = 8'h80;
	localparam logic [7:0] VSPF_BLANK_Y = 8'h10;
	// number of bytes in one timing code
	localparam logic [2:0] VSPF_CODE_LEN = 3'h4;

	// reset values
	localparam logic [15:0] VSPF_DATA_RST = 16'h0000;
	localparam logic [1:0] VSPF_CNT_RST = 2'h0;

	// raw sample width
	localparam int VSPF_RAW_W = 9;

endpackage

//--- core/vspf_code_if.sv
// video side port formatter: link to the timing code builder
// assumes both ends sit on the core clock
`timescale 1ns/1ps
interface vspf_code_if;
	logic field;
	logic vblank;
	logic eav;
	logic [7:0] xy;

	modport gen (
		input field,
		input vblank,
		input eav,
		output xy
	);

	modport user (
		output field,
		output vblank,
		output eav,
		input xy
	);
endinterface

//--- core/vspf_code_gen.sv
// video side port formatter: builds the fourth byte of a timing code
// assumes field, vblank and eav are stable while the byte is sent
`timescale 1ns/1ps
module vspf_code_gen (
	vspf_code_if.gen code
);
	// ----------------------------------------------------------------
	// status byte with protection bits
	// ----------------------------------------------------------------
	always_comb begin
		code.xy = {1'b1, code.field, code.vblank, code.eav,
			code.vblank ^ code.eav,
			code.field ^ code.eav,
			code.field ^ code.vblank,
			code.field ^ code.vblank ^ code.eav};
	end
endmodule

//--- core/vspf_top.sv
// video side port formatter: drives the local video side port pins
// assumes stream inputs come from logic on core_clk; rawClkIn is a pin
//
// Overview of operation
// - discrete-sync 8-bit mode: byte stream, hsync, vsync and active qualifier at full rate.
// - embedded-code mode: byte stream, timing by start and end codes in data; hsync, vsync and active pins are still driven.
// - VIP mode: 8 or 16 bit data with embedded timing codes, full rate.
// - zoomed-video mode: 16-bit pixels at half rate with discrete syncs.
// - direct 16-bit mode: full rate, hsync, vsync or field, clock reference qualifier.
// - raw digital-TV mode: 9-bit samples clocked by copy of the external clock.
// - VIP discontinuous stream: byte 00 sent on every empty cycle of active video; blanking levels are sent outside it.
// - discrete-sync standards: empty cycles marked by valid qualifier or by gated clock.
// - stream goes to side port, capture path, or both together.
// - port clock is regular except in raw mode and when gated on empty cycles: fixed number of core cycles per pixel.
`timescale 1ns/1ps
module vspf_top
	import vspf_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire vspf_mode_t cfgMode,
	input wire logic cfgVip16,
	input wire logic cfgGateClk,
	input wire logic cfgUseFid,
	input wire logic cfgToPort,
	input wire logic cfgToCapture,
	input wire logic [7:0] pixY,
	input wire logic [7:0] pixC,
	input wire logic pixValid,
	output logic pixReady,
	input wire logic hsyncIn,
	input wire logic vsyncIn,
	input wire logic fieldIn,
	input wire logic activeIn,
	input wire logic rawClkIn,
	input wire logic [VSPF_RAW_W-1:0] rawSample,
	output logic portClk,
	output logic [15:0] portData,
	output logic portOe,
	output logic portHsync,
	output logic portVsync,
	output logic portActive,
	output logic portQual,
	output logic [15:0] capData,
	output logic capValid
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		vspf_mode_t mode;
		logic [1:0] cnt;
		logic clk;
		logic gate;
		logic [15:0] data;
		logic oe;
		logic hs;
		logic vs;
		logic act;
		logic qual;
		logic ready;
		logic [2:0] codeCnt;
		logic eav;
		logic holdPend;
		logic [15:0] hold;
		logic holdValid;
		logic prevAct;
		logic phase;
		logic rawS1;
		logic rawS2;
		logic rawPrev;
		logic [15:0] cap;
		logic capV;
	} vspf_state_t;

	vspf_state_t st_r;
	vspf_state_t st_nxt;
	logic [1:0] rstSync_r;
	logic rstInt_n;

	vspf_code_if codeLink ();

	vspf_code_gen codeGen (
		.code(codeLink.gen)
	);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstSync_r <= 2'h0;
		end else begin
			rstSync_r <= {rstSync_r[0], 1'b1};
		end
	end
	assign rstInt_n = rstSync_r[1];

	function automatic logic isEmbedded(input vspf_mode_t m);
		isEmbedded = (m == VSPF_MODE_EMB656) || (m == VSPF_MODE_VIP);
	endfunction

	function automatic logic isWide(input vspf_mode_t m, input logic vip16);
		isWide = (m == VSPF_MODE_ZOOM) || (m == VSPF_MODE_DIRECT16) ||
			((m == VSPF_MODE_VIP) && vip16);
	endfunction

	function automatic logic tickAt(input vspf_mode_t m, input logic [1:0] c);
		tickAt = (m == VSPF_MODE_ZOOM) ? (c == 2'h3) : c[0];
	endfunction

	assign codeLink.field = fieldIn;
	assign codeLink.vblank = vsyncIn;
	assign codeLink.eav = st_r.eav;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic tick;
		logic take;
		logic wide;
		logic [15:0] word;
		logic [7:0] codeByte;
		tick = 1'b0;
		take = 1'b0;
		wide = 1'b0;
		word = VSPF_DATA_RST;
		codeByte = VSPF_PREAMBLE_LO;
		st_nxt = st_r;
		st_nxt.capV = 1'b0;
		st_nxt.rawS1 = rawClkIn;
		st_nxt.rawS2 = st_r.rawS1;
		st_nxt.rawPrev = st_r.rawS2;
		st_nxt.mode = cfgMode;
		st_nxt.oe = cfgToPort;
		wide = isWide(st_r.mode, cfgVip16);
		if (cfgMode != st_r.mode) begin
			// restart cleanly on a standard change
			st_nxt.cnt = VSPF_CNT_RST;
			st_nxt.codeCnt = 3'h0;
			st_nxt.holdPend = 1'b0;
			st_nxt.prevAct = 1'b0;
			st_nxt.gate = 1'b0;
			st_nxt.clk = 1'b0;
		end else if (st_r.mode == VSPF_MODE_RAWDTV) begin
			// forwarded copy of the external sampling clock
			st_nxt.clk = st_r.rawS2;
			if (!st_r.rawS2 && st_r.rawPrev) begin
				st_nxt.data = {7'h00, rawSample};
				st_nxt.qual = 1'b1;
				if (cfgToCapture) begin
					st_nxt.cap = {7'h00, rawSample};
					st_nxt.capV = 1'b1;
				end
			end
		end else begin
			st_nxt.cnt = st_r.cnt + 2'h1;
			tick = tickAt(st_r.mode, st_r.cnt);
			take = tick && st_r.ready;
			if (tick) begin
				st_nxt.gate = 1'b0;
				st_nxt.phase = ~st_r.phase;
				st_nxt.hs = hsyncIn;
				st_nxt.vs = (cfgUseFid && st_r.mode == VSPF_MODE_DIRECT16) ?
					fieldIn : vsyncIn;
				st_nxt.act = activeIn;
				st_nxt.prevAct = activeIn;
				word = wide ? {pixY, pixC} : {8'h00, pixY};
				if (isEmbedded(st_r.mode)) begin
					if (st_r.codeCnt != 3'h0) begin
						case (st_r.codeCnt)
							3'h4: codeByte = VSPF_PREAMBLE_HI;
							3'h1: codeByte = codeLink.xy;
							default: codeByte = VSPF_PREAMBLE_LO;
						endcase
						st_nxt.data = wide ? {codeByte, codeByte} : {8'h00, codeByte};
						st_nxt.codeCnt = st_r.codeCnt - 3'h1;
					end else if (take && activeIn != st_r.prevAct) begin
						// timing code first, the taken word waits
						st_nxt.hold = word;
						st_nxt.holdValid = pixValid;
						st_nxt.holdPend = 1'b1;
						st_nxt.eav = !activeIn;
						st_nxt.data = wide ? {2{VSPF_PREAMBLE_HI}} :
							{8'h00, VSPF_PREAMBLE_HI};
						st_nxt.codeCnt = VSPF_CODE_LEN - 3'h1;
					end else begin
						if (st_r.holdPend) begin
							word = st_r.hold;
							st_nxt.holdPend = 1'b0;
						end
						if (!activeIn) begin
							st_nxt.data = wide ? {VSPF_BLANK_Y, VSPF_BLANK_C} :
								{8'h00, st_r.phase ? VSPF_BLANK_Y : VSPF_BLANK_C};
						end else if (st_r.holdPend ? st_r.holdValid : pixValid) begin
							st_nxt.data = word;
						end else if (st_r.mode == VSPF_MODE_VIP) begin
							st_nxt.data = {2{VSPF_EMPTY_BYTE}};
						end else begin
							st_nxt.data = word;
						end
					end
					st_nxt.qual = 1'b1;
				end else begin
					st_nxt.data = word;
					st_nxt.qual = pixValid;
					st_nxt.gate = cfgGateClk && !pixValid;
				end
				if (take && pixValid && activeIn && cfgToCapture) begin
					st_nxt.cap = word;
					st_nxt.capV = 1'b1;
				end
			end
			// clock rises mid-period so data is stable at the rising edge
			if (st_r.mode == VSPF_MODE_ZOOM) begin
				st_nxt.clk = st_nxt.cnt[1] && !st_nxt.gate;
			end else begin
				st_nxt.clk = st_nxt.cnt[0] && !st_nxt.gate;
			end
		end
		// ready lines up with the next tick unless a code is pending
		st_nxt.ready = (st_nxt.mode == st_r.mode) &&
			(st_r.mode != VSPF_MODE_RAWDTV) &&
			tickAt(st_r.mode, st_nxt.cnt) &&
			(st_nxt.codeCnt == 3'h0) && !st_nxt.holdPend;
	end

	always_ff @(posedge core_clk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign pixReady = st_r.ready;
	assign portClk = st_r.clk;
	assign portData = st_r.data;
	assign portOe = st_r.oe;
	assign portHsync = st_r.hs;
	assign portVsync = st_r.vs;
	assign portActive = st_r.act;
	assign portQual = st_r.qual;
	assign capData = st_r.cap;
	assign capValid = st_r.capV;
endmodule

//--- verif/vspf_checker.sv
// video side port formatter: port timing checks
// assumes bound to vspf_top with cfgMode steady between resets
`timescale 1ns/1ps
module vspf_checker
	import vspf_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire vspf_mode_t cfgMode,
	input wire logic cfgGateClk,
	input wire logic cfgToCapture,
	input wire logic [7:0] pixY,
	input wire logic [7:0] pixC,
	input wire logic pixValid,
	input wire logic pixReady,
	input wire logic activeIn,
	input wire logic portClk,
	input wire logic [15:0] portData,
	input wire logic portQual,
	input wire logic capValid
);
	logic [2:0] age_r;
	logic act_r;
	logic live;
	logic disc;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			age_r <= 3'h0;
			act_r <= 1'h0;
		end else begin
			age_r <= (age_r == 3'h7) ? age_r : age_r + 3'h1;
			act_r <= pixReady ? activeIn : act_r;
		end
	end
	// mode register settles a few cycles after release
	assign live = age_r == 3'h7;
	assign disc = cfgMode inside {VSPF_MODE_DSYNC8, VSPF_MODE_ZOOM, VSPF_MODE_DIRECT16};
	default clocking @(posedge core_clk); endclocking
	default disable iff (!live);
	a_full_gap: assert property (pixReady && cfgMode != VSPF_MODE_ZOOM |=> !pixReady)
		else $error("take too soon");
	a_zoom_gap: assert property (pixReady && cfgMode == VSPF_MODE_ZOOM |=> !pixReady[*3] ##1 pixReady)
		else $error("zoom spacing");
	a_zoom_word: assert property (pixReady && cfgMode == VSPF_MODE_ZOOM |=> portData == {$past(pixY), $past(pixC)})
		else $error("zoom word");
	a_raw_idle: assert property (cfgMode == VSPF_MODE_RAWDTV |-> !pixReady)
		else $error("raw take");
	a_byte_pass: assert property (pixReady && cfgMode == VSPF_MODE_DSYNC8 |=> portData == {8'h00, $past(pixY)})
		else $error("byte pass");
	a_qual_valid: assert property (pixReady && disc |=> portQual == $past(pixValid))
		else $error("qualifier");
	a_vip_empty: assert property (pixReady && cfgMode == VSPF_MODE_VIP && !pixValid && activeIn && act_r |=> portData[7:0] == VSPF_EMPTY_BYTE)
		else $error("empty marker");
	a_clk_walk: assert property (pixReady && cfgMode == VSPF_MODE_DSYNC8 && !cfgGateClk |=> !portClk ##1 portClk)
		else $error("clock walk");
	a_cap_take: assert property (pixReady && pixValid && activeIn && cfgToCapture |=> capValid)
		else $error("capture");
	cover property (pixReady && cfgMode == VSPF_MODE_VIP && !pixValid);
	cover property (pixReady && cfgMode == VSPF_MODE_ZOOM);
	cover property (capValid && cfgMode == VSPF_MODE_RAWDTV);
endmodule

//--- verif/vspf_sink.sv
// video side port formatter: far-side receiver and raw clock source
// assumes portClk is a clean registered level
`timescale 1ns/1ps
module vspf_sink (
	input wire logic portClk,
	input wire logic [15:0] portData,
	input wire logic portQual,
	output logic rawClkIn,
	output logic [8:0] rawSample
);
	logic [15:0] got[$];
	initial begin
		rawClkIn = 1'h0;
		rawSample = 9'h000;
	end
	always #200 rawClkIn = ~rawClkIn;
	always @(posedge rawClkIn) rawSample <= rawSample + 9'h0A7;
	always @(posedge portClk) begin
		if (portQual) got.push_back(portData);
	end
endmodule

//--- verif/vspf_tb_top.sv
// video side port formatter: self-checking bench
// assumes a 20 MHz core clock and the receiver model on the port
`timescale 1ns/1ps
module vspf_tb_top
	import vspf_pkg::*;
;
	logic core_clk = 1'h0, rst_n = 1'h0, cfgVip16 = 1'h0, cfgGateClk = 1'h0, cfgUseFid = 1'h0;
	logic cfgToPort = 1'h0, cfgToCapture = 1'h0, pixValid = 1'h0, hsyncIn = 1'h0;
	logic vsyncIn = 1'h0, fieldIn = 1'h0, activeIn = 1'h0, expQ, pend = 1'h0;
	logic expOe = 1'h0, expCv = 1'h0;
	logic [7:0] x;
	logic [7:0] pixY = 8'h00, pixC = 8'h00;
	vspf_mode_t cfgMode = VSPF_MODE_DSYNC8;
	logic pixReady, portClk, portOe, portHsync, portVsync, portActive, portQual, capValid;
	logic [15:0] portData, capData, expD, expS;
	logic rawClkIn;
	logic [8:0] rawSample;
	logic [31:0] seed = 32'hBF9356F6;
	int n_mismatch = 0, checks = 0, takes = 0, i;
	always #25 core_clk = ~core_clk;
	vspf_top dut_u (.*);
	vspf_sink sink_u (.*);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic cmp(input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic run(input vspf_mode_t m, input logic g);
		@(posedge core_clk);
		rst_n <= 1'h0;
		cfgMode <= m;
		cfgGateClk <= g;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'h1;
		takes = 0;
		sink_u.got.delete();
		repeat (300) @(posedge core_clk);
	endtask
	// model of the discrete modes, random drive
	always @(posedge core_clk) begin
		// skip the edge at which a new reset has just cleared the outputs
		if (pend && rst_n) begin
			cmp(expD, portData);
			cmp({15'h0000, expQ}, {15'h0000, portQual});
			cmp(expS, {13'h0000, portHsync, portVsync, portActive});
		end
		if (rst_n && takes > 0 && cfgMode != VSPF_MODE_RAWDTV) begin
			cmp({15'h0000, expOe}, {15'h0000, portOe});
			cmp({15'h0000, expCv}, {15'h0000, capValid});
			if (expCv) cmp(expD, capData);
		end
		if (capValid && cfgMode == VSPF_MODE_RAWDTV) begin
			cmp({7'h00, rawSample}, portData);
			cmp({7'h00, rawSample}, capData);
		end
		takes += pixReady;
		pend = pixReady && cfgMode inside {VSPF_MODE_DSYNC8, VSPF_MODE_ZOOM, VSPF_MODE_DIRECT16};
		expD = (cfgMode inside {VSPF_MODE_ZOOM, VSPF_MODE_DIRECT16} ||
			(cfgMode == VSPF_MODE_VIP && cfgVip16)) ? {pixY, pixC} : {8'h00, pixY};
		expS = {13'h0000, hsyncIn,
			(cfgUseFid && cfgMode == VSPF_MODE_DIRECT16) ? fieldIn : vsyncIn, activeIn};
		expQ = pixValid;
		expOe = cfgToPort;
		expCv = pixReady && pixValid && activeIn && cfgToCapture;
		seed = lfsr(seed);
		pixY <= seed[7:0];
		pixC <= seed[15:8];
		pixValid <= seed[16];
		hsyncIn <= seed[17];
		vsyncIn <= seed[18];
		fieldIn <= seed[19];
		activeIn <= (cfgMode inside {VSPF_MODE_EMB656, VSPF_MODE_VIP}) | seed[20];
		cfgToPort <= seed[21];
		cfgToCapture <= seed[22];
		cfgUseFid <= seed[23];
	end
	initial begin
		run(VSPF_MODE_DSYNC8, 1'h0);
		run(VSPF_MODE_ZOOM, 1'h0);
		run(VSPF_MODE_DIRECT16, 1'h1);
		run(VSPF_MODE_VIP, 1'h0);
		cfgVip16 <= 1'h1;
		run(VSPF_MODE_VIP, 1'h0);
		cfgVip16 <= 1'h0;
		run(VSPF_MODE_RAWDTV, 1'h0);
		cmp(16'h0000, takes[15:0]);
		run(VSPF_MODE_EMB656, 1'h0);
		i = 0;
		while (i < sink_u.got.size() - 3 && sink_u.got[i][7:0] !== 8'hFF) i++;
		cmp(16'hFF00, {sink_u.got[i][7:0], sink_u.got[i+1][7:0]});
		cmp(16'h0000, {8'h00, sink_u.got[i+2][7:0]});
		// start code: marker bit set, end flag clear, protection bits follow
		x = sink_u.got[i+3][7:0];
		cmp({8'h00, 1'h1, x[6:5], 1'h0, x[5], x[6], x[6] ^ x[5], x[6] ^ x[5]}, {8'h00, x});
		close_out;
	end
endmodule
bind vspf_top vspf_checker chk_u (.*);
